// >>> dcbf_consts.svh
`ifndef DCBF_CONSTS_SVH
`define DCBF_CONSTS_SVH
// Storage geometry: 1K words of 32 data plus 4 parity bits
`define DCBF_DATA_W 32
`define DCBF_PAR_W 4
`define DCBF_ADDR_W 10
`define DCBF_PTR_W 11
`define DCBF_DEPTH 11'h400
`define DCBF_PTR_MAX 11'h7FF
// Crossing stages for each pointer direction
`define DCBF_WSYNC 2
`define DCBF_RSYNC 3
// Least reset hold in clock cycles
`define DCBF_RESET_HOLD 3
// Register map (byte addresses)
`define DCBF_REG_CTRL 8'h00
`define DCBF_REG_FILL_OFS 8'h04
`define DCBF_REG_DRAIN_OFS 8'h08
`define DCBF_REG_STATUS 8'h0C
`define DCBF_REG_POINTERS 8'h10
// Control fields and reset values
`define DCBF_CTRL_LOOKAHEAD 0
`define DCBF_CTRL_SINGLE 1
`define DCBF_CTRL_RST 2'h0
`define DCBF_FILL_OFS_RST 11'h004
`define DCBF_DRAIN_OFS_RST 11'h004
`endif

// >>> dcbf_fifo.sv
//Function
// (R1) Geometry fixed at 1K by 36
// (R2) One port writes, other reads
// (R3) Read and write widths equal
// (R4) Write enable stores data plus parity
// (R5) Read enable moves next word out
// (R6) Internal pointers exposed, wrap to zero
// (R7) User stops on full or empty
// (R8) Write while full flags overflow, ignored
// (R9) Read while empty flags underflow
// (R10) Violations keep contents and pointers
// (R11) Full flag blocks further writes
// (R12) Empty flag blocks further reads
// (R13) Fill and drain warnings, set thresholds
// (R14) Standard mode needs read for first word
// (R15) Lookahead shows first word unread
// (R16) Capacity depth plus one or two
// (R17) Clocks free running, maybe unrelated
// (R18) Use multirate for unrelated clocks
// (R19) Single clock setting adds no latency
// (R20) Single clock setting shares one clock
// (R21) Async reset clears pointers and flags
// (R22) Data and parity out registered
// (R23) Reset sets empty, drain; clears full, fill
// (R24) Enables held low during reset
// (R25) Empty falls after three or four clocks
// (R26) Full falls four clocks after read
// (R27) Reset spares memory and output register
// (R28) Pointers cross through gray synchronisers
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "dcbf_consts.svh"
module dcbf_fifo
  import dcbf_pkg::*;
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST_B,
  input  wire logic [`DCBF_DATA_W-1:0] WRITE_DATA_IN,
  input  wire logic [`DCBF_PAR_W-1:0]  WRITE_PARITY_IN,
  input  wire logic                    WRITE_ENABLE_IN,
  input  wire logic                    READ_ENABLE_IN,
  output logic      [`DCBF_DATA_W-1:0] READ_DATA_OUT,
  output logic      [`DCBF_PAR_W-1:0]  READ_PARITY_OUT,
  output logic                         FULL,
  output logic                         FILL_WARNING,
  output logic                         EMPTY,
  output logic                         DRAIN_WARNING,
  output logic                         OVERFLOW_ERROR,
  output logic                         UNDERFLOW_ERROR,
  output logic      [`DCBF_PTR_W-1:0]  READ_POINTER_VALUE,
  output logic      [`DCBF_PTR_W-1:0]  WRITE_POINTER_VALUE,
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [31:0]             REG_RDATA
);

  localparam int PW = `DCBF_PTR_W;

  // Gray to binary, used on both crossed pointers
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  dcbf_word_t       mem [`DCBF_DEPTH];                          // see R1
  dcbf_word_t       stage_word;
  dcbf_word_t       out_word;
  logic             stage_valid;
  logic             out_valid;
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW-1:0]    wgray;
  logic [PW-1:0]    rgray;
  logic [PW-1:0]    wg_sync [`DCBF_WSYNC];
  logic [PW-1:0]    rg_sync [`DCBF_RSYNC];
  logic [PW-1:0]    wptr_r;
  logic [PW-1:0]    rptr_w;
  logic [PW-1:0]    next_wptr;
  logic [PW-1:0]    used_w;
  logic [PW-1:0]    used_r;
  logic [PW:0]      entries;
  logic [1:0]       ctrl;
  logic [PW-1:0]    fill_ofs;
  logic [PW-1:0]    drain_ofs;
  dcbf_mode_t       mode;
  logic             single;
  logic             wr_ok;
  logic             pop;
  logic             out_take;
  logic             stage_load;
  logic             mem_has;
  dcbf_flags_t      flags;

  assign mode   = dcbf_mode_t'(ctrl[`DCBF_CTRL_LOOKAHEAD]);
  assign single = ctrl[`DCBF_CTRL_SINGLE];

  // Write side: accept only when not full
  assign wr_ok     = WRITE_ENABLE_IN & ~FULL;                   // see R11
  assign next_wptr = wptr + PW'(wr_ok);

  // Storage write, no reset so contents survive it
  always_ff @(posedge SYS_CLK) begin
    if (wr_ok) begin                                            // see R4
      mem[wptr[`DCBF_ADDR_W-1:0]] <= {WRITE_PARITY_IN, WRITE_DATA_IN};
    end
  end

  // Write pointer, wraps naturally at its top value
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wptr  <= '0;                                              // see R21
      wgray <= '0;
    end else begin
      wptr  <= next_wptr;                                       // see R6
      wgray <= bin2gray(next_wptr);
    end
  end

  // Read pointer crossing into the write side
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rg_sync[0] <= '0;
    end else begin
      rg_sync[0] <= rgray;                                      // see R28
    end
  end

  for (genvar g = 1; g < `DCBF_RSYNC; g++) begin : g_rsync
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        rg_sync[g] <= '0;
      end else begin
        rg_sync[g] <= rg_sync[g-1];
      end
    end
  end

  // Single clock setting bypasses the crossing
  assign rptr_w = single ? rptr : gray2bin(rg_sync[`DCBF_RSYNC-1]); // see R19
  assign used_w = next_wptr - rptr_w;

  // Full, fill warning and overflow, on the write side
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FULL           <= 1'b0;                                   // see R23
      FILL_WARNING   <= 1'b0;
      OVERFLOW_ERROR <= 1'b0;
    end else begin
      FULL           <= (used_w == `DCBF_DEPTH);                // see R26
      FILL_WARNING   <= (`DCBF_DEPTH - used_w) <= fill_ofs;     // see R13
      OVERFLOW_ERROR <= WRITE_ENABLE_IN & FULL;                 // see R8
    end
  end

  // Write pointer crossing into the read side
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wg_sync[0] <= '0;
    end else begin
      wg_sync[0] <= wgray;                                      // see R28
    end
  end

  for (genvar g = 1; g < `DCBF_WSYNC; g++) begin : g_wsync  // see R25
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        wg_sync[g] <= '0;
      end else begin
        wg_sync[g] <= wg_sync[g-1];
      end
    end
  end

  assign wptr_r  = single ? wptr : gray2bin(wg_sync[`DCBF_WSYNC-1]);
  assign mem_has = (wptr_r != rptr);

  // Empty depends on mode: stage in standard, output in lookahead
  assign EMPTY = (mode == DCBF_LOOKAHEAD) ? ~out_valid : ~stage_valid;
  assign pop   = READ_ENABLE_IN & ~EMPTY;                       // see R12

  // Output loads on read, or on its own when lookahead
  assign out_take = (mode == DCBF_LOOKAHEAD) ?
                    (stage_valid & (~out_valid | pop)) :        // see R15
                    pop;                                        // see R14
  assign stage_load = mem_has & (~stage_valid | out_take);

  // Read pointer and prefetch stage valid
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rptr        <= '0;                                        // see R21
      rgray       <= '0;
      stage_valid <= 1'b0;
      out_valid   <= 1'b0;
    end else begin
      rptr        <= rptr + PW'(stage_load);                    // see R6
      rgray       <= bin2gray(rptr + PW'(stage_load));
      stage_valid <= stage_load | (stage_valid & ~out_take);    // see R16
      out_valid   <= (mode == DCBF_LOOKAHEAD) &
                     (out_take | (out_valid & ~pop));
    end
  end

  // Data path registers, kept through reset
  always_ff @(posedge SYS_CLK) begin
    if (stage_load) begin
      stage_word <= mem[rptr[`DCBF_ADDR_W-1:0]];                // see R2
    end
    if (out_take) begin
      out_word <= stage_word;                                   // see R5, R27
    end
  end

  assign READ_DATA_OUT   = out_word.data;                       // see R22
  assign READ_PARITY_OUT = out_word.parity;                     // see R3

  // Drain warning and underflow, on the read side
  assign used_r  = wptr_r - rptr;
  assign entries = {1'b0, used_r} + (PW+1)'(stage_valid)
                   + (PW+1)'(out_valid);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DRAIN_WARNING   <= 1'b1;                                  // see R23
      UNDERFLOW_ERROR <= 1'b0;
    end else begin
      DRAIN_WARNING   <= entries <= {1'b0, drain_ofs};          // see R13
      UNDERFLOW_ERROR <= READ_ENABLE_IN & EMPTY;                // see R9
    end
  end

  assign READ_POINTER_VALUE  = rptr;
  assign WRITE_POINTER_VALUE = wptr;

  // Configuration registers
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl      <= `DCBF_CTRL_RST;
      fill_ofs  <= `DCBF_FILL_OFS_RST;
      drain_ofs <= `DCBF_DRAIN_OFS_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `DCBF_REG_CTRL:      ctrl      <= REG_WDATA[1:0];
        `DCBF_REG_FILL_OFS:  fill_ofs  <= REG_WDATA[PW-1:0];
        `DCBF_REG_DRAIN_OFS: drain_ofs <= REG_WDATA[PW-1:0];
        default:             ctrl      <= ctrl;
      endcase
    end
  end

  assign flags = '{underflow:  UNDERFLOW_ERROR,
                   overflow:   OVERFLOW_ERROR,
                   drain_warn: DRAIN_WARNING,
                   empty:      EMPTY,
                   fill_warn:  FILL_WARNING,
                   full:       FULL};

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `DCBF_REG_CTRL:      REG_RDATA <= {30'h0, ctrl};
        `DCBF_REG_FILL_OFS:  REG_RDATA <= {21'h0, fill_ofs};
        `DCBF_REG_DRAIN_OFS: REG_RDATA <= {21'h0, drain_ofs};
        `DCBF_REG_STATUS:    REG_RDATA <= {26'h0, flags};
        `DCBF_REG_POINTERS:  REG_RDATA <= {5'h0, wptr, 5'h0, rptr};
        default:             REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // Checks
  write_ignored_a: assert property (                            // see R10
    WRITE_ENABLE_IN && FULL |=> wptr == $past(wptr))
    else $error("write taken while full");

  overflow_flag_a: assert property (                            // see R8
    WRITE_ENABLE_IN && FULL |=> OVERFLOW_ERROR)
    else $error("overflow not flagged");

  underflow_flag_a: assert property (                           // see R9
    READ_ENABLE_IN && EMPTY |=> UNDERFLOW_ERROR && !$past(pop))
    else $error("underflow not flagged");

  pointer_wrap_a: assert property (                             // see R6
    wptr == `DCBF_PTR_MAX && wr_ok |=> wptr == '0)
    else $error("write pointer did not wrap");

  empty_std_a: assert property (                                // see R25
    !single && mode == DCBF_STANDARD && wptr == rptr && wr_ok
    && !stage_valid |=> EMPTY [*3] ##1 !EMPTY)
    else $error("standard empty latency wrong");

  empty_look_a: assert property (                               // see R25
    !single && mode == DCBF_LOOKAHEAD && wptr == rptr && wr_ok
    && !stage_valid && !out_valid |=> EMPTY [*4] ##1 !EMPTY)
    else $error("lookahead empty latency wrong");

  full_release_a: assert property (                             // see R26
    !single && FULL && stage_load |=> FULL [*4] ##1 !FULL)
    else $error("full release latency wrong");

  single_empty_a: assert property (                             // see R19
    single && mode == DCBF_STANDARD && wptr == rptr && wr_ok
    && !stage_valid |=> ##1 !EMPTY)
    else $error("single clock empty latency wrong");

  data_order_a: assert property (                               // see R5
    mode == DCBF_STANDARD && pop |=> READ_DATA_OUT ==
    $past(stage_word.data))
    else $error("read data not next word");

  look_fill_a: assert property (                                // see R15
    mode == DCBF_LOOKAHEAD && stage_valid && !out_valid |=> !EMPTY
    && READ_DATA_OUT == $past(stage_word.data))
    else $error("lookahead word not shown");

  read_wrap_a: assert property (                                // see R6
    rptr == `DCBF_PTR_MAX && stage_load |=> rptr == '0)
    else $error("read pointer did not wrap");

  overflow_drop_a: assert property (                            // see R8
    !(WRITE_ENABLE_IN && FULL) |=> !OVERFLOW_ERROR)
    else $error("overflow flag without cause");

  underflow_drop_a: assert property (                           // see R9
    !(READ_ENABLE_IN && EMPTY) |=> !UNDERFLOW_ERROR)
    else $error("underflow flag without cause");

endmodule // dcbf_fifo

// >>> dcbf_pkg.sv
`include "dcbf_consts.svh"
package dcbf_pkg;
  // One stored entry: parity above data
  typedef struct packed {
    logic [`DCBF_PAR_W-1:0]  parity;
    logic [`DCBF_DATA_W-1:0] data;
  } dcbf_word_t;
  // Status flags as seen in the status register
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic drain_warn;
    logic empty;
    logic fill_warn;
    logic full;
  } dcbf_flags_t;
  // First-word handling
  typedef enum logic [0:0] {
    DCBF_STANDARD  = 1'b0,
    DCBF_LOOKAHEAD = 1'b1
  } dcbf_mode_t;
endpackage

// >>> dcbf_user.sv
`timescale 1ns/100ps
module dcbf_user
  import dcbf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic push,
  input  wire logic pop,
  input  wire logic rude,
  input  wire logic full,
  input  wire logic empty,
  output logic      we,
  output logic      re,
  output dcbf_word_t word
);
  logic [15:0] cnt;
  // Enables low in reset, flags obeyed unless told to be rude
  assign we = rst_b & push & (rude | ~full);
  assign re = rst_b & pop & (rude | ~empty);
  // Word is count, inverse, parity nibble
  assign word = {cnt[3:0], ~cnt, cnt};
  // Count moves only on writes the buffer takes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
    end else if (we && !full) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule // dcbf_user

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  import dcbf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        push, pop, rude, rwr, rrd;
  logic [7:0]  radr;
  logic [31:0] rwd, rrdata, d;
  logic        we, re, full, fillw, empty, drainw, ovf, unf;
  logic [31:0] dout;
  logic [3:0]  pout;
  logic [10:0] rptr, wptr, p;
  dcbf_word_t  word;
  int          miscompares = 0;
  int          tests_run = 0;
  int          rdn = 0;
  int          n;
  dcbf_fifo uut (.SYS_CLK(clk), .RST_B(rst_b), .WRITE_DATA_IN(word.data),
    .WRITE_PARITY_IN(word.parity), .WRITE_ENABLE_IN(we),
    .READ_ENABLE_IN(re), .READ_DATA_OUT(dout), .READ_PARITY_OUT(pout),
    .FULL(full), .FILL_WARNING(fillw), .EMPTY(empty),
    .DRAIN_WARNING(drainw), .OVERFLOW_ERROR(ovf), .UNDERFLOW_ERROR(unf),
    .READ_POINTER_VALUE(rptr), .WRITE_POINTER_VALUE(wptr),
    .REG_ADDR(radr), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd),
    .REG_RDATA(rrdata));
  dcbf_user usr (.clk(clk), .rst_b(rst_b), .push(push), .pop(pop),
    .rude(rude), .full(full), .empty(empty), .we(we), .re(re),
    .word(word));
  // One free-running clock feeds both sides
  always #12.5 clk = ~clk;
  task chk(string nm, logic [35:0] e, logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Expected word for read number k
  function automatic logic [35:0] ew(int k);
    logic [15:0] c;
    c = k[15:0];
    return {c[3:0], ~c, c};
  endfunction
  task final_report;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    rwr <= 1'b1; radr <= a; rwd <= v;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a);
    @(posedge clk);
    rrd <= 1'b1; radr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1 d = rrdata;
  endtask
  task rd1;
    @(posedge clk) pop <= 1'b1;
    @(posedge clk) pop <= 1'b0;
    #1;
  endtask
  task t_reset;
    chk("empty", 1, empty);
    chk("drain", 1, drainw);
    chk("full", 0, full);
    chk("fill", 0, fillw);
    chk("ptrs", 0, {rptr, wptr});
    reg_rd(8'h0C);
    chk("status", 32'h0000000C, d);
    reg_rd(8'h04);
    chk("fill ofs", 32'h00000004, d);
    reg_rd(8'h14);
    chk("unmapped", 0, d);
    reg_rd(8'h08);
    chk("drain ofs", 32'h00000004, d);
    reg_wr(8'h08, 32'h00000010);
    reg_rd(8'h08);
    chk("drain ofs", 32'h00000010, d);
  endtask
  // First word into an empty buffer, then a refused read
  task t_first(input logic [1:0] ctl, input int lag);
    reg_wr(8'h00, {30'h0, ctl});
    reg_rd(8'h00);
    chk("ctrl", {30'h0, ctl}, d);
    @(posedge clk) push <= 1'b1;
    @(posedge clk) push <= 1'b0;
    #1 n = 0;
    while (empty && n < 10) begin
      tick;
      n++;
    end
    chk("empty lag", lag, n);
    if (ctl[0]) begin
      chk("lookahead", ew(rdn), {pout, dout});
      rd1;
      rdn++;
    end else begin
      tests_run++;
      if ({pout, dout} === ew(rdn)) begin
        $display("BAD early word expected other seen %h", dout);
        miscompares++;
      end
      rd1;
      chk("word", ew(rdn), {pout, dout});
      rdn++;
    end
    chk("empty", 1, empty);
    p = rptr;
    @(posedge clk) {rude, pop} <= 2'b11;
    @(posedge clk) {rude, pop} <= 2'b00;
    #1 chk("underflow", 1, unf);
    chk("rptr", p, rptr);
  endtask
  // Fill to full, refuse a write, release and drain all
  task t_fill(input logic [10:0] ep);
    @(posedge clk) push <= 1'b1;
    n = 0;
    while (!full && n < 1100) begin
      tick;
      n++;
    end
    @(posedge clk) push <= 1'b0;
    repeat (8) tick;
    chk("wptr", ep, wptr);
    chk("full", 1, full);
    chk("fill", 1, fillw);
    chk("drain", 0, drainw);
    @(posedge clk) {rude, push} <= 2'b11;
    @(posedge clk) {rude, push} <= 2'b00;
    #1 chk("overflow", 1, ovf);
    chk("wptr", ep, wptr);
    rd1;
    chk("word", ew(rdn), {pout, dout});
    rdn++;
    n = 0;
    while (full && n < 10) begin
      tick;
      n++;
    end
    // Freed entry reaches the write side four edges after the read
    chk("full lag", 4, n);
    repeat (1024) begin
      n = 0;
      while (empty && n < 10) begin
        tick;
        n++;
      end
      rd1;
      chk("word", ew(rdn), {pout, dout});
      rdn++;
    end
    chk("empty", 1, empty);
    chk("drain", 1, drainw);
    reg_rd(8'h10);
    chk("pointers", {5'h0, ep, 5'h0, ep}, d);
  endtask
  initial begin
    {push, pop, rude, rwr, rrd} = 5'h00;
    radr = 8'h00;
    rwd = 32'h00000000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    tick;
    t_reset;
    t_first(2'h0, 3);
    t_first(2'h1, 4);
    t_first(2'h2, 1);
    reg_wr(8'h00, 32'h00000000);
    t_fill(11'h404);
    t_fill(11'h005);
    final_report;
  end
  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    miscompares++;
    final_report;
  end
endmodule // tb
